// ### verilog/scf_pkg.sv
// package: register map, field layout and reset values of the page-6 configuration bank
package scf_pkg;
  // ==========================================================
  // page selection and register offsets (byte addresses = 4 * index)
  localparam logic [2:0] SCF_PAGE_SEL_VALUE = 3'h6;
  localparam logic [5:0] SCF_IDX_PAGE_SELECT = 6'h13;
  localparam logic [5:0] SCF_IDX_CLOCK_CTRL = 6'h14;
  localparam logic [5:0] SCF_IDX_HEADER_WORD = 6'h15;
  localparam logic [5:0] SCF_IDX_SRC_IP_HIGH = 6'h16;
  localparam logic [5:0] SCF_IDX_SRC_IP_LOW = 6'h17;
  localparam logic [5:0] SCF_IDX_PARTIAL_SUM = 6'h18;
  localparam logic [5:0] SCF_IDX_PIN_ROUTING = 6'h19;
  localparam int SCF_ADDR_LSB = 2;
  // ==========================================================
  // field positions
  localparam int SCF_CLK_EN_BIT = 15;
  localparam int SCF_CLK_ROOT_BIT = 14;
  localparam int SCF_CLK_SPEED_BIT = 13;
  localparam int SCF_TX_PIN_LSB = 4;
  localparam int SCF_PIN_SEL_W = 4;
  localparam int SCF_DIV_W = 8;
  // ==========================================================
  // reset values and writable masks
  localparam logic [15:0] SCF_CLOCK_CTRL_RST = 16'h800a;
  localparam logic [15:0] SCF_CLOCK_CTRL_MASK = 16'he0ff;
  localparam logic [15:0] SCF_PIN_ROUTING_MASK = 16'h00ff;
  localparam logic [15:0] SCF_ZERO_RST = 16'h0000;
  localparam logic [2:0] SCF_PAGE_RST = 3'h0;
  localparam logic [7:0] SCF_DIV_MIN = 8'h02;
  // ==========================================================
  // timing: internal source clock
  localparam int SCF_SRC_CLK_MHZ = 250;
endpackage

// ### verilog/scf_cfg_if.sv
// interface: configuration fields handed from the register bank to the helper modules
interface scf_cfg_if;
  logic clk_en;
  logic root_sel;
  logic [7:0] divisor;
  logic [3:0] tx_pin_sel;
  logic [3:0] rx_pin_sel;
  modport bank (output clk_en, output root_sel, output divisor, output tx_pin_sel,
                output rx_pin_sel);
  modport clkdiv (input clk_en, input root_sel, input divisor);
  modport router (input tx_pin_sel, input rx_pin_sel);
endinterface

// ### verilog/scf_clkdiv.sv
// module: divide-by-n generator for the synchronized clock output
module scf_clkdiv (
  input wire logic src_clk_i,
  input wire logic src_resetn_i,
  input wire logic ce_i,
  input wire logic phase_generation_module_tick_i,
  input wire logic frequency_controlled_oscillator_tick_i,
  scf_cfg_if.clkdiv cfg,
  output logic sync_clk_o
);
  import scf_pkg::*;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic out_reg;
  logic out_next;
  logic tick;
  logic run;
  logic [7:0] half;
  // ==========================================================
  // root pick and divider
  assign tick = cfg.root_sel ? phase_generation_module_tick_i
                             : frequency_controlled_oscillator_tick_i;
  assign run = cfg.clk_en && (cfg.divisor >= SCF_DIV_MIN);
  assign half = {1'b0, cfg.divisor[7:1]};
  // next values: count source ticks, high for first half of divisor
  always_comb begin
    cnt_next = cnt_reg;
    out_next = out_reg;
    if (!run) begin
      cnt_next = 8'h00;
      out_next = 1'b0;
    end else if (tick) begin
      if (cnt_reg >= cfg.divisor - 8'h01) begin
        cnt_next = 8'h00;
      end else begin
        cnt_next = cnt_reg + 8'h01;
      end
      out_next = (cnt_next < half);
    end
  end
  // registers
  always_ff @(posedge src_clk_i) begin
    if (!src_resetn_i) begin
      cnt_reg <= 8'h00;
      out_reg <= 1'b0;
    end else if (ce_i) begin
      cnt_reg <= cnt_next;
      out_reg <= out_next;
    end
  end
  assign sync_clk_o = out_reg;
  chk_stop_bad_div: assert property (@(posedge src_clk_i) disable iff (!src_resetn_i)
    (ce_i && cfg.divisor < SCF_DIV_MIN) |=> !sync_clk_o) else $error("clock runs on bad divisor");
  chk_stop_disabled: assert property (@(posedge src_clk_i) disable iff (!src_resetn_i)
    (ce_i && !cfg.clk_en) |=> !sync_clk_o) else $error("clock runs while disabled");
endmodule

// ### verilog/scf_pin_router.sv
// module: route start-of-frame indications onto general-purpose pins
module scf_pin_router #(
  parameter int PINS = 12
) (
  input wire logic tx_sof_i,
  input wire logic rx_sof_i,
  input wire logic [PINS-1:0] other_func_i,
  scf_cfg_if.router cfg,
  output logic [PINS-1:0] pin_o
);
  import scf_pkg::*;
  logic [PINS-1:0] tx_map;
  logic [PINS-1:0] rx_map;
  // ==========================================================
  // one-hot pin decode, zero select or out-of-range drives nothing
  always_comb begin
    tx_map = '0;
    rx_map = '0;
    for (int i = 0; i < PINS; i++) begin
      if (cfg.tx_pin_sel == 4'(i + 1)) tx_map[i] = tx_sof_i;
      if (cfg.rx_pin_sel == 4'(i + 1)) rx_map[i] = rx_sof_i;
    end
  end
  // shared pins: all functions or-ed together
  assign pin_o = tx_map | rx_map | other_func_i;
endmodule

// ### verilog/scf_cfg_bank.sv
// module: page-6 configuration bank for sync clock output, status frame header and sof routing
//
// Design decision made here: the APB interface to the registers.
module scf_cfg_bank #(
  parameter int PINS = 12
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // synchronized clock output, runs on the internal source clock
  input wire logic src_clk_i,
  input wire logic src_resetn_i,
  input wire logic phase_generation_module_tick_i,
  input wire logic frequency_controlled_oscillator_tick_i,
  output logic sync_clk_o,
  output logic sync_clk_fast_edge_o,
  // status frame header content towards the receive data path framer
  input wire logic [15:0] frame_total_len_i,
  input wire logic [15:0] frame_ident_i,
  output logic [15:0] status_header_word_o,
  output logic [31:0] status_src_ip_o,
  output logic [15:0] status_ip_checksum_o,
  // start-of-frame routing
  input wire logic tx_sof_i,
  input wire logic rx_sof_i,
  input wire logic [PINS-1:0] other_func_i,
  output logic [PINS-1:0] gpio_o
);
  import scf_pkg::*;
  initial begin
    if (PINS < 1 || PINS > 15) $error("PINS must be 1..15");
  end
  // ==========================================================
  // register state
  logic [2:0] page_reg;
  logic [2:0] page_next;
  logic [15:0] clk_ctrl_reg;
  logic [15:0] clk_ctrl_next;
  logic [15:0] header_reg;
  logic [15:0] header_next;
  logic [15:0] ip_high_reg;
  logic [15:0] ip_high_next;
  logic [15:0] ip_low_reg;
  logic [15:0] ip_low_next;
  logic [15:0] psum_reg;
  logic [15:0] psum_next;
  logic [15:0] route_reg;
  logic [15:0] route_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic err_reg;
  logic err_next;
  logic [15:0] csum_reg;
  logic [15:0] csum_next;
  logic [5:0] idx;
  logic page_ok;
  logic access;
  logic wr;
  logic [15:0] wd;
  logic hit_bank;
  logic [31:0] rmux;
  logic [17:0] sum_wide;
  logic [16:0] sum_fold;
  scf_cfg_if cfg ();
  // ==========================================================
  // apb decode
  assign idx = paddr_i[SCF_ADDR_LSB +: 6];
  assign page_ok = (page_reg == SCF_PAGE_SEL_VALUE);
  assign access = psel_i && penable_i && ce_i;
  assign wr = access && pwrite_i;
  assign wd = pwdata_i[15:0];
  assign pready_o = 1'b1;
  assign hit_bank = page_ok && (idx >= SCF_IDX_CLOCK_CTRL) && (idx <= SCF_IDX_PIN_ROUTING);
  // read mux, reserved and upper bits read zero
  always_comb begin
    rmux = 32'h0000_0000;
    if (idx == SCF_IDX_PAGE_SELECT) begin
      rmux = {29'h0000_0000, page_reg};
    end else if (page_ok) begin
      unique case (idx)
        SCF_IDX_CLOCK_CTRL: rmux = {16'h0000, clk_ctrl_reg & SCF_CLOCK_CTRL_MASK};
        SCF_IDX_HEADER_WORD: rmux = {16'h0000, header_reg};
        SCF_IDX_SRC_IP_HIGH: rmux = {16'h0000, ip_high_reg};
        SCF_IDX_SRC_IP_LOW: rmux = {16'h0000, ip_low_reg};
        SCF_IDX_PARTIAL_SUM: rmux = {16'h0000, psum_reg};
        SCF_IDX_PIN_ROUTING: rmux = {16'h0000, route_reg & SCF_PIN_ROUTING_MASK};
        default: rmux = 32'h0000_0000;
      endcase
    end
  end
  // next values of the register file
  always_comb begin
    page_next = page_reg;
    clk_ctrl_next = clk_ctrl_reg;
    header_next = header_reg;
    ip_high_next = ip_high_reg;
    ip_low_next = ip_low_reg;
    psum_next = psum_reg;
    route_next = route_reg;
    rdata_next = rdata_reg;
    err_next = 1'b0;
    if (access) begin
      rdata_next = pwrite_i ? 32'h0000_0000 : rmux;
      err_next = !(hit_bank || idx == SCF_IDX_PAGE_SELECT);
    end
    if (wr && idx == SCF_IDX_PAGE_SELECT) begin
      page_next = wd[2:0];
    end
    if (wr && hit_bank) begin
      unique case (idx)
        SCF_IDX_CLOCK_CTRL: clk_ctrl_next = wd & SCF_CLOCK_CTRL_MASK;
        SCF_IDX_HEADER_WORD: header_next = wd;
        SCF_IDX_SRC_IP_HIGH: ip_high_next = wd;
        SCF_IDX_SRC_IP_LOW: ip_low_next = wd;
        SCF_IDX_PARTIAL_SUM: psum_next = wd;
        SCF_IDX_PIN_ROUTING: route_next = wd & SCF_PIN_ROUTING_MASK;
        default: psum_next = psum_reg;
      endcase
    end
  end
  // register file flops
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      page_reg <= SCF_PAGE_RST;
      clk_ctrl_reg <= SCF_CLOCK_CTRL_RST;
      header_reg <= SCF_ZERO_RST;
      ip_high_reg <= SCF_ZERO_RST;
      ip_low_reg <= SCF_ZERO_RST;
      psum_reg <= SCF_ZERO_RST;
      route_reg <= SCF_ZERO_RST;
      rdata_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
    end else if (ce_i) begin
      page_reg <= page_next;
      clk_ctrl_reg <= clk_ctrl_next;
      header_reg <= header_next;
      ip_high_reg <= ip_high_next;
      ip_low_reg <= ip_low_next;
      psum_reg <= psum_next;
      route_reg <= route_next;
      rdata_reg <= rdata_next;
      err_reg <= err_next;
    end
  end
  // combinational answer in the access cycle, zero-wait slave
  assign prdata_o = rmux;
  assign pslverr_o = access && !(hit_bank || idx == SCF_IDX_PAGE_SELECT);
  // ==========================================================
  // ip checksum completion: ones-complement add, then invert
  assign sum_wide = {2'b00, psum_reg} + {2'b00, frame_total_len_i} + {2'b00, frame_ident_i};
  assign sum_fold = {1'b0, sum_wide[15:0]} + {15'h0000, sum_wide[17:16]};
  always_comb begin
    csum_next = ~(sum_fold[15:0] + {15'h0000, sum_fold[16]});
  end
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      csum_reg <= 16'hffff;
    end else if (ce_i) begin
      csum_reg <= csum_next;
    end
  end
  // ==========================================================
  // header content for the status frame framer on the receive data path
  assign status_header_word_o = header_reg;
  assign status_src_ip_o = {ip_high_reg[7:0], ip_high_reg[15:8],
                            ip_low_reg[7:0], ip_low_reg[15:8]};
  assign status_ip_checksum_o = csum_reg;
  assign sync_clk_fast_edge_o = clk_ctrl_reg[SCF_CLK_SPEED_BIT];
  // config fields for helpers
  assign cfg.clk_en = clk_ctrl_reg[SCF_CLK_EN_BIT];
  assign cfg.root_sel = clk_ctrl_reg[SCF_CLK_ROOT_BIT];
  assign cfg.divisor = clk_ctrl_reg[SCF_DIV_W-1:0];
  assign cfg.tx_pin_sel = route_reg[SCF_TX_PIN_LSB +: SCF_PIN_SEL_W];
  assign cfg.rx_pin_sel = route_reg[SCF_PIN_SEL_W-1:0];
  // ==========================================================
  // helpers
  scf_clkdiv u_clkdiv (
    .src_clk_i(src_clk_i),
    .src_resetn_i(src_resetn_i),
    .ce_i(ce_i),
    .phase_generation_module_tick_i(phase_generation_module_tick_i),
    .frequency_controlled_oscillator_tick_i(frequency_controlled_oscillator_tick_i),
    .cfg(cfg.clkdiv),
    .sync_clk_o(sync_clk_o)
  );
  scf_pin_router #(.PINS(PINS)) u_router (
    .tx_sof_i(tx_sof_i),
    .rx_sof_i(rx_sof_i),
    .other_func_i(other_func_i),
    .cfg(cfg.router),
    .pin_o(gpio_o)
  );
  // ==========================================================
  // checks
  sequence wr_bank_s;
    psel_i && penable_i && pwrite_i && ce_i && !page_ok && hit_bank == 1'b0 &&
      idx == SCF_IDX_HEADER_WORD;
  endsequence
  chk_page_gate_write: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr_bank_s |=> $stable(header_reg)) else $error("write landed off page");
  chk_page_gate_read: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (access && !pwrite_i && !page_ok && idx != SCF_IDX_PAGE_SELECT) |-> prdata_o == 32'h0)
    else $error("read visible off page");
  chk_reserved_zero: assert property (@(posedge clk_i) disable iff (!resetn_i)
    clk_ctrl_reg[12:8] == 5'h00 && route_reg[15:8] == 8'h00) else $error("reserved bits set");
  chk_header_write: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (wr && page_ok && idx == SCF_IDX_HEADER_WORD) |=> status_header_word_o == $past(wd))
    else $error("header word not taken");
  chk_src_ip_order: assert property (@(posedge clk_i) disable iff (!resetn_i)
    status_src_ip_o[31:24] == ip_high_reg[7:0] && status_src_ip_o[7:0] == ip_low_reg[15:8])
    else $error("source address byte order");
  chk_checksum_calc: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (ce_i && $stable(psum_reg) && $stable(frame_total_len_i) && $stable(frame_ident_i))
    ##1 ce_i |=> status_ip_checksum_o == $past(csum_next)) else $error("checksum wrong");
  chk_route_zero: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (cfg.tx_pin_sel == 4'h0 && cfg.rx_pin_sel == 4'h0) |-> gpio_o == other_func_i)
    else $error("disabled route drives pin");
  chk_route_or: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (cfg.rx_pin_sel == 4'h1 && rx_sof_i) |-> gpio_o[0]) else $error("rx sof not on pin 1");
  chk_share_pin: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (other_func_i[0]) |-> gpio_o[0]) else $error("other function masked");
endmodule

// ### tb/scf_mac_model.sv
// local mac model: supplies per-frame length and identification, takes header content
module scf_mac_model (
  input wire logic clk_i,
  input wire logic [1:0] frame_idx_i,
  input wire logic [15:0] header_word_i,
  input wire logic [15:0] checksum_i,
  output logic [15:0] total_len_o,
  output logic [15:0] ident_o,
  output logic [15:0] last_header_o
);
  // ==========================================================
  // per-frame values, one pair for each frame the mac receives
  always_comb begin
    total_len_o = 16'h002c + {14'h0000, frame_idx_i} * 16'h0010;
    ident_o = (frame_idx_i == 2'h3) ? 16'hffff : 16'h1e00 + {14'h0000, frame_idx_i};
  end
  // header arrives on the receive data path, captured each cycle
  always_ff @(posedge clk_i) begin
    last_header_o <= header_word_i;
  end
endmodule

// ### tb/test_scf_cfg_bank.sv
// testbench of the page-6 configuration bank
module test_scf_cfg_bank;
  timeunit 1ns;
  timeprecision 100ps;
  import scf_pkg::*;
  logic clk_i = 0, src_clk_i = 0, resetn_i = 0, src_resetn_i = 0;
  logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, sync_clk, fast_edge;
  logic tx_sof = 0, rx_sof = 0, phase_tick = 1, osc_tick = 1, ce = 1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, src_ip, rd;
  logic [15:0] hdr, csum, len, ident, mac_hdr;
  logic [11:0] other = 12'h000, gpio;
  logic [1:0] fidx = 2'h0;
  logic err;
  int bad_count = 0, checks_done = 0, cyc = 0;
  // ==========================================================
  // clocks: 100 ns bus clock, 4 ns internal source clock
  always #50 clk_i = ~clk_i;
  always #2 src_clk_i = ~src_clk_i;
  scf_cfg_bank #(.PINS(12)) i_scf_cfg_bank (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .src_clk_i(src_clk_i), .src_resetn_i(src_resetn_i),
    .phase_generation_module_tick_i(phase_tick),
    .frequency_controlled_oscillator_tick_i(osc_tick),
    .sync_clk_o(sync_clk), .sync_clk_fast_edge_o(fast_edge),
    .frame_total_len_i(len), .frame_ident_i(ident), .status_header_word_o(hdr),
    .status_src_ip_o(src_ip), .status_ip_checksum_o(csum), .tx_sof_i(tx_sof),
    .rx_sof_i(rx_sof), .other_func_i(other), .gpio_o(gpio));
  scf_mac_model i_scf_mac_model (.clk_i(clk_i), .frame_idx_i(fidx), .header_word_i(hdr),
    .checksum_i(csum), .total_len_o(len), .ident_o(ident), .last_header_o(mac_hdr));
  // ==========================================================
  // comparison, verdict and timeout
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (bad_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      give_verdict();
    end
  end
  // apb transfer: setup, then access held until pready is sampled high
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // count high samples of the output clock over 40 source cycles
  task automatic clk_highs(input int exp, input string name);
    int n;
    n = 0;
    repeat (40) @(posedge src_clk_i);
    repeat (40) begin
      @(posedge src_clk_i);
      n += (sync_clk === 1'b1);
    end
    chk(name, n, exp);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_page_and_reset();
    apb(0, SCF_IDX_CLOCK_CTRL, 0);
    chk("offpage err", err, 1);
    chk("offpage data", rd, 0);
    apb(1, SCF_IDX_PAGE_SELECT, 32'h0000_0006);
    apb(0, SCF_IDX_CLOCK_CTRL, 0);
    chk("clock ctrl reset", rd, 32'h0000_800a);
    apb(0, SCF_IDX_HEADER_WORD, 0);
    chk("header reset", rd, 0);
    apb(0, SCF_IDX_PIN_ROUTING, 0);
    chk("routing reset", rd, 0);
    apb(0, 6'h1f, 0);
    chk("unmapped err", err, 1);
  endtask
  task automatic t_reserved();
    apb(1, SCF_IDX_CLOCK_CTRL, 32'hffff_ffff);
    apb(0, SCF_IDX_CLOCK_CTRL, 0);
    chk("clock ctrl mask", rd, 32'h0000_e0ff);
    chk("speed select", fast_edge, 32'h0000_0001);
    apb(1, SCF_IDX_PIN_ROUTING, 32'hffff_ffff);
    apb(0, SCF_IDX_PIN_ROUTING, 0);
    chk("routing mask", rd, 32'h0000_00ff);
  endtask
  task automatic t_frame_fields();
    apb(1, SCF_IDX_HEADER_WORD, 32'h0000_5a3c);
    apb(1, SCF_IDX_SRC_IP_HIGH, 32'h0000_a8c0);
    apb(1, SCF_IDX_SRC_IP_LOW, 32'h0000_0701);
    @(posedge clk_i);
    chk("header out", hdr, 32'h0000_5a3c);
    @(posedge clk_i);
    chk("mac header", mac_hdr, 32'h0000_5a3c);
    chk("src ip", src_ip, 32'hc0a8_0107);
  endtask
  // clock enable low: a write must not land
  task automatic t_freeze();
    ce <= 1'b0;
    apb(1, SCF_IDX_HEADER_WORD, 32'h0000_1234);
    ce <= 1'b1;
    apb(0, SCF_IDX_HEADER_WORD, 0);
    chk("frozen header", rd, 32'h0000_5a3c);
  endtask
  task automatic t_checksum();
    logic [17:0] s;
    logic [15:0] f;
    apb(1, SCF_IDX_PARTIAL_SUM, 32'h0000_f3a1);
    for (int i = 0; i < 4; i++) begin
      fidx <= i[1:0];
      repeat (3) @(posedge clk_i);
      s = 18'(16'hf3a1) + 18'(len) + 18'(ident);
      s = {2'b00, s[15:0]} + {16'h0000, s[17:16]};
      f = s[15:0] + {14'h0000, s[17:16]};
      chk("ip checksum", csum, {16'h0000, ~f});
    end
  endtask
  task automatic t_routing();
    logic [11:0] e;
    other <= 12'h801;
    for (int p = 0; p < 16; p++) begin
      apb(1, SCF_IDX_PIN_ROUTING, {24'h0, p[3:0], 4'((p + 5) % 16)});
      for (int k = 0; k < 4; k++) begin
        tx_sof <= k[0];
        rx_sof <= k[1];
        @(posedge clk_i);
        @(negedge clk_i);
        e = 12'h801;
        if (k[0] && p >= 1 && p <= 12) e[p - 1] = 1'b1;
        if (k[1] && (p + 5) % 16 >= 1 && (p + 5) % 16 <= 12) e[(p + 5) % 16 - 1] = 1'b1;
        chk("gpio", gpio, e);
      end
    end
  endtask
  task automatic t_clock_out();
    apb(1, SCF_IDX_CLOCK_CTRL, 32'h0000_8004);
    clk_highs(20, "div4 osc");
    osc_tick <= 1'b0;
    apb(1, SCF_IDX_CLOCK_CTRL, 32'h0000_c005);
    clk_highs(16, "div5 phase");
    apb(1, SCF_IDX_CLOCK_CTRL, 32'h0000_c001);
    clk_highs(0, "div1 stop");
    apb(1, SCF_IDX_CLOCK_CTRL, 32'h0000_4004);
    clk_highs(0, "disabled");
    osc_tick <= 1'b1;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    src_resetn_i <= 1'b1;
    t_page_and_reset();
    t_reserved();
    t_frame_fields();
    t_freeze();
    t_checksum();
    t_routing();
    t_clock_out();
    give_verdict();
  end
endmodule
